// [rtl/t3_rx_pkg.sv]
package t3_rx_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam logic [9:0] OFS_ERR_STATUS = 10'h126;
  localparam logic [9:0] OFS_ALARM_LATCH = 10'h128;
  localparam logic [9:0] OFS_ERR_LATCH = 10'h12A;
  localparam logic [9:0] OFS_ALARM_IE = 10'h12C;

  // ****************************************************************
  // Reset values and implemented-bit masks
  // ****************************************************************
  localparam logic [15:0] ALARM_IE_RESET = 16'h0000;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  localparam logic [15:0] ALARM_MASK = 16'h0FFF;
  localparam logic [15:0] ERR_LATCH_MASK = 16'h0F0F;
  localparam logic [15:0] M23_HOLD_MASK = 16'h0C0C;
  localparam logic [3:0] ERR_STATUS_RESET = 4'h0;
  localparam logic [11:0] LIVE_RESET = 12'h000;

  // ****************************************************************
  // Alarm latch bit positions
  // ****************************************************************
  localparam int BIT_FMT_MISMATCH = 11;
  localparam int BIT_APP_ID = 10;
  localparam int BIT_IDLE = 9;
  localparam int BIT_UNFRAMED_ONES = 8;
  localparam int BIT_MULTIFRAME_LOSS = 7;
  localparam int BIT_SEVERE_ERR = 6;
  localparam int BIT_REALIGN = 5;
  localparam int BIT_FRAME_LOSS = 4;
  localparam int BIT_REMOTE_DEFECT = 3;
  localparam int BIT_ALARM_IND = 2;
  localparam int BIT_OUT_OF_FRAME = 1;
  localparam int BIT_SIGNAL_LOSS = 0;

  // ****************************************************************
  // Error latch and error status bit positions
  // ****************************************************************
  localparam int BIT_CBIT_ERR = 11;
  localparam int BIT_FAR_ERR = 10;
  localparam int BIT_PBIT_ERR = 9;
  localparam int BIT_FRM_ERR = 8;
  localparam int BIT_CBIT_NZ = 3;
  localparam int BIT_FAR_NZ = 2;
  localparam int BIT_PBIT_NZ = 1;
  localparam int BIT_FRM_NZ = 0;

  // ****************************************************************
  // Framing count select and error gating
  // ****************************************************************
  localparam logic [1:0] FSEL_OOF = 2'h0;
  localparam logic [1:0] FSEL_M_AND_F = 2'h1;
  localparam logic [1:0] FSEL_F_ONLY = 2'h2;
  localparam logic [1:0] FSEL_M_ONLY = 2'h3;
  localparam logic [1:0] HOLDOFF_FRAMES = 2'h2;
  localparam logic [1:0] HOLDOFF_IDLE = 2'h0;

endpackage

// [rtl/sticky_flag_bank.sv]
`timescale 1ns/1ps
module sticky_flag_bank #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  input wire logic [WIDTH-1:0] hold_zero_i,
  output logic [WIDTH-1:0] flags_o
);

  typedef struct packed {
    logic [WIDTH-1:0] flags;
  } bank_t;

  bank_t st_ff;
  bank_t nxt_st;

  // ****************************************************************
  // Per-bit sticky flag
  // ****************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    for (int i = 0; i < WIDTH; i++)
    begin
      // Set beats a same-cycle clear so no event is lost
      if (hold_zero_i[i])
        nxt_st.flags[i] = 1'b0;
      else if (set_i[i])
        nxt_st.flags[i] = 1'b1;
      else if (clr_i[i])
        nxt_st.flags[i] = 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign flags_o = st_ff.flags;

endmodule

// [rtl/t3_rx_status_latch_irq.sv]
`timescale 1ns/1ps
module t3_rx_status_latch_irq (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic [9:0] addr_i,
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [15:0] wr_data_i,
  input wire logic m23_mode_i,
  input wire logic [1:0] framing_count_select_i,
  input wire logic err_count_ungated_i,
  input wire logic port_global_irq_en_i,
  input wire logic format_mismatch_i,
  input wire logic app_id_channel_i,
  input wire logic idle_i,
  input wire logic unframed_all_ones_i,
  input wire logic multiframe_loss_i,
  input wire logic severely_errored_i,
  input wire logic frame_loss_i,
  input wire logic remote_defect_i,
  input wire logic alarm_indication_i,
  input wire logic out_of_frame_i,
  input wire logic signal_loss_i,
  input wire logic frame_realign_i,
  input wire logic frame_start_i,
  input wire logic oof_onset_i,
  input wire logic f_bit_err_i,
  input wire logic m_bit_err_i,
  input wire logic pbit_parity_err_i,
  input wire logic cbit_parity_err_i,
  input wire logic far_block_err_i,
  input wire logic cbit_count_nz_i,
  input wire logic far_block_count_nz_i,
  input wire logic pbit_count_nz_i,
  input wire logic framing_count_nz_i,
  output logic [15:0] rd_data_o,
  output logic port_irq_o,
  output logic framing_err_event_o,
  output logic pbit_err_event_o,
  output logic cbit_err_event_o,
  output logic far_block_err_event_o
);

  typedef struct packed {
    logic primed;
    logic [11:0] live_prev;
    logic [3:0] nz_status;
    logic [1:0] holdoff;
    logic framing_evt;
    logic pbit_evt;
    logic cbit_evt;
    logic far_evt;
    logic [15:0] alarm_ie;
    logic [15:0] rd_data;
    logic irq;
  } ctl_t;

  ctl_t st_ff;
  ctl_t nxt_st;

  logic [15:0] alarm_flags;
  logic [15:0] err_flags;
  logic [15:0] alarm_set;
  logic [15:0] alarm_clr;
  logic [15:0] err_set;
  logic [15:0] err_clr;
  logic [15:0] err_hold;
  logic [11:0] live;
  logic [3:0] nz_now;
  logic suppress;
  logic holdoff_on;
  logic frm_raw;
  logic frm_q;
  logic pbit_q;
  logic cbit_q;
  logic far_q;
  logic wr_alarm_latch;
  logic wr_err_latch;
  logic wr_alarm_ie;

  // ****************************************************************
  // Live alarm vector, realign position carries no level
  // ****************************************************************
  always_comb
  begin
    live = t3_rx_pkg::LIVE_RESET;
    live[t3_rx_pkg::BIT_FMT_MISMATCH] = format_mismatch_i;
    live[t3_rx_pkg::BIT_APP_ID] = app_id_channel_i;
    live[t3_rx_pkg::BIT_IDLE] = idle_i;
    live[t3_rx_pkg::BIT_UNFRAMED_ONES] = unframed_all_ones_i;
    live[t3_rx_pkg::BIT_MULTIFRAME_LOSS] = multiframe_loss_i;
    live[t3_rx_pkg::BIT_SEVERE_ERR] = severely_errored_i;
    live[t3_rx_pkg::BIT_FRAME_LOSS] = frame_loss_i;
    live[t3_rx_pkg::BIT_REMOTE_DEFECT] = remote_defect_i;
    live[t3_rx_pkg::BIT_ALARM_IND] = alarm_indication_i;
    live[t3_rx_pkg::BIT_OUT_OF_FRAME] = out_of_frame_i;
    live[t3_rx_pkg::BIT_SIGNAL_LOSS] = signal_loss_i;
  end

  // ****************************************************************
  // Error event qualification
  // ****************************************************************
  always_comb
  begin
    suppress = !err_count_ungated_i
      && (out_of_frame_i || alarm_indication_i);
    // Parity and far-end errors also skipped for two frames after OOF
    holdoff_on = !err_count_ungated_i
      && (st_ff.holdoff != t3_rx_pkg::HOLDOFF_IDLE);
    frm_raw = 1'b0;
    unique case (framing_count_select_i)
      t3_rx_pkg::FSEL_OOF: frm_raw = oof_onset_i;
      t3_rx_pkg::FSEL_M_AND_F: frm_raw = f_bit_err_i || m_bit_err_i;
      t3_rx_pkg::FSEL_F_ONLY: frm_raw = f_bit_err_i;
      t3_rx_pkg::FSEL_M_ONLY: frm_raw = m_bit_err_i;
    endcase
    // OOF onsets count regardless of the gating control
    if (framing_count_select_i == t3_rx_pkg::FSEL_OOF)
      frm_q = frm_raw;
    else
      frm_q = frm_raw && !suppress;
    pbit_q = pbit_parity_err_i && !suppress && !holdoff_on;
    cbit_q = cbit_parity_err_i && !suppress && !holdoff_on
      && !m23_mode_i;
    far_q = far_block_err_i && !suppress && !holdoff_on && !m23_mode_i;
  end

  // ****************************************************************
  // Count-nonzero status
  // ****************************************************************
  always_comb
  begin
    nz_now = t3_rx_pkg::ERR_STATUS_RESET;
    nz_now[t3_rx_pkg::BIT_CBIT_NZ] = cbit_count_nz_i && !m23_mode_i;
    nz_now[t3_rx_pkg::BIT_FAR_NZ] = far_block_count_nz_i
      && !m23_mode_i;
    nz_now[t3_rx_pkg::BIT_PBIT_NZ] = pbit_count_nz_i;
    nz_now[t3_rx_pkg::BIT_FRM_NZ] = framing_count_nz_i;
  end

  // ****************************************************************
  // Register write decode
  // ****************************************************************
  always_comb
  begin
    wr_alarm_latch = wr_en_i && addr_i == t3_rx_pkg::OFS_ALARM_LATCH;
    wr_err_latch = wr_en_i && addr_i == t3_rx_pkg::OFS_ERR_LATCH;
    // Status offset has no decode, so writes there are dropped
    wr_alarm_ie = wr_en_i && addr_i == t3_rx_pkg::OFS_ALARM_IE;
  end

  // ****************************************************************
  // Latch set and clear terms
  // ****************************************************************
  always_comb
  begin
    alarm_set = '0;
    if (st_ff.primed)
    begin
      // Any edge counts for the plain alarm conditions
      alarm_set[11:0] = live ^ st_ff.live_prev;
      alarm_set[t3_rx_pkg::BIT_FMT_MISMATCH] = format_mismatch_i
        && !st_ff.live_prev[t3_rx_pkg::BIT_FMT_MISMATCH];
    end
    alarm_set[t3_rx_pkg::BIT_REALIGN] = frame_realign_i;
    alarm_set = alarm_set & t3_rx_pkg::ALARM_MASK;

    err_set = '0;
    err_set[t3_rx_pkg::BIT_CBIT_ERR] = cbit_q;
    err_set[t3_rx_pkg::BIT_FAR_ERR] = far_q;
    err_set[t3_rx_pkg::BIT_PBIT_ERR] = pbit_q;
    err_set[t3_rx_pkg::BIT_FRM_ERR] = frm_q;
    err_set[3:0] = nz_now & ~st_ff.nz_status;
    err_hold = m23_mode_i ? t3_rx_pkg::M23_HOLD_MASK : '0;

    alarm_clr = '0;
    err_clr = '0;
    if (wr_alarm_latch)
      alarm_clr = wr_data_i;
    if (wr_err_latch)
      err_clr = wr_data_i;
  end

  sticky_flag_bank #(
    .WIDTH(16)
  ) u_alarm_latch (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .set_i(alarm_set),
    .clr_i(alarm_clr),
    .hold_zero_i(~t3_rx_pkg::ALARM_MASK),
    .flags_o(alarm_flags)
  );

  sticky_flag_bank #(
    .WIDTH(16)
  ) u_err_latch (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .set_i(err_set & t3_rx_pkg::ERR_LATCH_MASK),
    .clr_i(err_clr),
    .hold_zero_i(err_hold | ~t3_rx_pkg::ERR_LATCH_MASK),
    .flags_o(err_flags)
  );

  // ****************************************************************
  // Control state, register access, interrupt
  // ****************************************************************
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.primed = 1'b1;
    nxt_st.live_prev = live;
    nxt_st.nz_status = nz_now;

    // Holdoff covers the frame where OOF ends and the next one
    if (st_ff.primed && st_ff.live_prev[t3_rx_pkg::BIT_OUT_OF_FRAME]
        && !out_of_frame_i)
      nxt_st.holdoff = t3_rx_pkg::HOLDOFF_FRAMES;
    else if (frame_start_i && st_ff.holdoff != t3_rx_pkg::HOLDOFF_IDLE)
      nxt_st.holdoff = st_ff.holdoff - 2'h1;

    nxt_st.framing_evt = frm_q;
    nxt_st.pbit_evt = pbit_q;
    nxt_st.cbit_evt = cbit_q;
    nxt_st.far_evt = far_q;

    if (wr_alarm_ie)
      nxt_st.alarm_ie = wr_data_i & t3_rx_pkg::ALARM_MASK;

    if (rd_en_i)
    begin
      unique case (addr_i)
        t3_rx_pkg::OFS_ERR_STATUS:
          nxt_st.rd_data = {12'h000, st_ff.nz_status};
        t3_rx_pkg::OFS_ALARM_LATCH:
          nxt_st.rd_data = alarm_flags;
        t3_rx_pkg::OFS_ERR_LATCH:
          nxt_st.rd_data = err_flags;
        t3_rx_pkg::OFS_ALARM_IE:
          nxt_st.rd_data = st_ff.alarm_ie;
        default:
          nxt_st.rd_data = 16'h0000;
      endcase
    end

    // Level request; drops once every enabled flag is gone or the global enable is off
    nxt_st.irq = port_global_irq_en_i
      && |(alarm_flags & st_ff.alarm_ie);
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      st_ff.primed <= 1'b0;
      st_ff.live_prev <= t3_rx_pkg::LIVE_RESET;
      st_ff.nz_status <= t3_rx_pkg::ERR_STATUS_RESET;
      st_ff.holdoff <= t3_rx_pkg::HOLDOFF_IDLE;
      st_ff.framing_evt <= 1'b0;
      st_ff.pbit_evt <= 1'b0;
      st_ff.cbit_evt <= 1'b0;
      st_ff.far_evt <= 1'b0;
      st_ff.alarm_ie <= t3_rx_pkg::ALARM_IE_RESET;
      st_ff.rd_data <= 16'h0000;
      st_ff.irq <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_o = st_ff.rd_data;
  assign port_irq_o = st_ff.irq;
  assign framing_err_event_o = st_ff.framing_evt;
  assign pbit_err_event_o = st_ff.pbit_evt;
  assign cbit_err_event_o = st_ff.cbit_evt;
  assign far_block_err_event_o = st_ff.far_evt;

endmodule

// [verif/t3_rx_irq_props.sv]
`timescale 1ns/1ps
module t3_rx_irq_props (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic m23_mode_i,
  input wire logic [1:0] framing_count_select_i,
  input wire logic err_count_ungated_i,
  input wire logic port_global_irq_en_i,
  input wire logic alarm_indication_i,
  input wire logic oof_onset_i,
  input wire logic f_bit_err_i,
  input wire logic pbit_parity_err_i,
  input wire logic cbit_parity_err_i,
  input wire logic far_block_err_i,
  input wire logic port_irq_o,
  input wire logic framing_err_event_o,
  input wire logic pbit_err_event_o,
  input wire logic cbit_err_event_o,
  input wire logic far_block_err_event_o
);
  // ****************************************************************
  // Event qualification and interrupt gating
  // ****************************************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  a_pbit_evt_pass:
  assert property (err_count_ungated_i && pbit_parity_err_i |=>
    pbit_err_event_o) else $error("pbit event lost");
  a_pbit_evt_cause:
  assert property (pbit_err_event_o |-> $past(pbit_parity_err_i))
    else $error("pbit event without error");
  a_cbit_evt_pass:
  assert property (!m23_mode_i && err_count_ungated_i && cbit_parity_err_i
    |=> cbit_err_event_o) else $error("cbit event lost");
  a_cbit_m23_drop:
  assert property (m23_mode_i |=> !cbit_err_event_o)
    else $error("cbit event in m23");
  a_far_m23_drop:
  assert property (m23_mode_i |=> !far_block_err_event_o)
    else $error("far block event in m23");
  a_frm_oof_sel:
  assert property (framing_count_select_i == 2'h0 && oof_onset_i |=>
    framing_err_event_o) else $error("oof onset not counted");
  a_frm_fonly_sel:
  assert property (framing_count_select_i == 2'h2 && !f_bit_err_i |=>
    !framing_err_event_o) else $error("framing event without f bit");
  a_gate_ais_drop:
  assert property (!err_count_ungated_i && alarm_indication_i |=>
    !pbit_err_event_o) else $error("pbit event during ais");
  a_irq_global_off:
  assert property (!port_global_irq_en_i |=> !port_irq_o)
    else $error("irq without global enable");
endmodule

bind t3_rx_status_latch_irq t3_rx_irq_props chk_u (
  .sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .m23_mode_i(m23_mode_i),
  .framing_count_select_i(framing_count_select_i),
  .err_count_ungated_i(err_count_ungated_i),
  .port_global_irq_en_i(port_global_irq_en_i),
  .alarm_indication_i(alarm_indication_i), .oof_onset_i(oof_onset_i),
  .f_bit_err_i(f_bit_err_i), .pbit_parity_err_i(pbit_parity_err_i),
  .cbit_parity_err_i(cbit_parity_err_i), .far_block_err_i(far_block_err_i),
  .port_irq_o(port_irq_o), .framing_err_event_o(framing_err_event_o),
  .pbit_err_event_o(pbit_err_event_o), .cbit_err_event_o(cbit_err_event_o),
  .far_block_err_event_o(far_block_err_event_o));

// [verif/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [9:0] addr = 10'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rdat;
  logic m23 = 1'b0;
  logic ung = 1'b1;
  logic glb = 1'b0;
  logic [1:0] sel = 2'h0;
  logic [11:0] live = 12'h000;
  logic [6:0] ev = 7'h00;
  logic [3:0] nz = 4'h0;
  logic irq;
  logic frm_evt;
  logic [15:0] ef;
  logic [31:0] r;
  int error_cnt = 0;
  int checks_done = 0;
  integer seed = 13670;
  always #50 sys_clk_i = ~sys_clk_i;
  t3_rx_status_latch_irq dut_u (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .addr_i(addr), .rd_en_i(rd), .wr_en_i(wr), .wr_data_i(wd),
    .m23_mode_i(m23), .framing_count_select_i(sel), .err_count_ungated_i(ung),
    .port_global_irq_en_i(glb), .format_mismatch_i(live[11]),
    .app_id_channel_i(live[10]), .idle_i(live[9]),
    .unframed_all_ones_i(live[8]), .multiframe_loss_i(live[7]),
    .severely_errored_i(live[6]), .frame_realign_i(live[5]),
    .frame_loss_i(live[4]), .remote_defect_i(live[3]),
    .alarm_indication_i(live[2]), .out_of_frame_i(live[1]),
    .signal_loss_i(live[0]), .oof_onset_i(ev[0]), .f_bit_err_i(ev[1]),
    .m_bit_err_i(ev[2]), .pbit_parity_err_i(ev[3]),
    .cbit_parity_err_i(ev[4]), .far_block_err_i(ev[5]),
    .frame_start_i(ev[6]), .cbit_count_nz_i(nz[3]),
    .far_block_count_nz_i(nz[2]), .pbit_count_nz_i(nz[1]),
    .framing_count_nz_i(nz[0]), .rd_data_o(rdat), .port_irq_o(irq),
    .framing_err_event_o(frm_evt), .pbit_err_event_o(), .cbit_err_event_o(),
    .far_block_err_event_o());
  // ****************************************************************
  // Bus and check helpers
  // ****************************************************************
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    checks_done++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic exp_frm(input logic [1:0] s,
    input logic [6:0] e, input logic u, input logic oof, input logic ais);
    logic raw;
    case (s)
      2'h0: raw = e[0];
      2'h1: raw = e[1] || e[2];
      2'h2: raw = e[1];
      default: raw = e[2];
    endcase
    // OOF onsets count even while errors are gated
    exp_frm = (s == 2'h0 || u || !(oof || ais)) ? raw : 1'b0;
  endfunction
  task automatic wreg(input logic [9:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge sys_clk_i);
    wr <= 1'b0;
  endtask
  task automatic cr(input string nm, input logic [9:0] a,
    input logic [15:0] e);
    @(posedge sys_clk_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge sys_clk_i);
    rd <= 1'b0;
    @(posedge sys_clk_i);
    #1 chk(nm, e, rdat);
  endtask
  task automatic ck_irq(input string nm, input logic e);
    #1 chk(nm, {15'h0000, e}, {15'h0000, irq});
    @(posedge sys_clk_i);
  endtask
  task automatic pulse(input logic [6:0] e);
    @(posedge sys_clk_i);
    ev <= e;
    @(posedge sys_clk_i);
    ev <= 7'h00;
    tick(2);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    tick(20);
    reset_n_i <= 1'b1;
    cr("ie reset", 10'h12C, 16'h0000);
    cr("latch reset", 10'h128, 16'h0000);
    cr("unmapped", 10'h130, 16'h0000);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge sys_clk_i);
      live[i] <= 1'b1;
      // Realign is a pulse, not a level
      if (i == 5)
      begin
        @(posedge sys_clk_i);
        live[5] <= 1'b0;
      end
      tick(2);
      cr("alarm rise", 10'h128, 16'h0001 << i);
      wreg(10'h128, 16'hFFFF);
      cr("alarm clear", 10'h128, 16'h0000);
      @(posedge sys_clk_i);
      live[i] <= 1'b0;
      tick(2);
      r = (i == 11 || i == 5) ? 32'h0 : 32'h1 << i;
      cr("alarm fall", 10'h128, r[15:0]);
      wreg(10'h128, 16'hFFFF);
    end
    wreg(10'h12C, 16'hFFFF);
    glb <= 1'b1;
    live[0] <= 1'b1;
    tick(4);
    ck_irq("irq on", 1'b1);
    glb <= 1'b0;
    tick(3);
    ck_irq("irq global", 1'b0);
    glb <= 1'b1;
    wreg(10'h12C, 16'h0FFE);
    tick(2);
    ck_irq("irq masked", 1'b0);
    wreg(10'h12C, 16'h0FFF);
    tick(2);
    ck_irq("irq back", 1'b1);
    // Clear lands with a fresh change: the change must survive
    addr <= 10'h128;
    wd <= 16'h0001;
    wr <= 1'b1;
    live[0] <= 1'b0;
    @(posedge sys_clk_i);
    wr <= 1'b0;
    cr("set wins", 10'h128, 16'h0001);
    wreg(10'h128, 16'h0001);
    tick(3);
    ck_irq("irq cleared", 1'b0);
    cr("enable rw", 10'h12C, 16'h0FFF);
    m23 <= 1'b1;
    pulse(7'h30);
    cr("m23 hold", 10'h12A, 16'h0000);
    m23 <= 1'b0;
    pulse(7'h38);
    cr("err latch", 10'h12A, 16'h0E00);
    for (int s = 0; s < 4; s++)
    begin
      wreg(10'h12A, 16'hFFFF);
      sel <= s[1:0];
      pulse(7'h02);
      r = (s == 1 || s == 2) ? 32'h100 : 32'h0;
      cr("framing f sel", 10'h12A, r[15:0]);
      wreg(10'h12A, 16'hFFFF);
      pulse(7'h04);
      r = (s == 1 || s == 3) ? 32'h100 : 32'h0;
      cr("framing m sel", 10'h12A, r[15:0]);
    end
    wreg(10'h12A, 16'hFFFF);
    sel <= 2'h0;
    ung <= 1'b0;
    live[2] <= 1'b1;
    pulse(7'h09);
    cr("gated err", 10'h12A, 16'h0100);
    wreg(10'h12A, 16'hFFFF);
    nz <= 4'hF;
    tick(3);
    cr("nz status", 10'h126, 16'h000F);
    cr("nz rise", 10'h12A, 16'h000F);
    wreg(10'h12A, 16'hFFFF);
    m23 <= 1'b1;
    tick(3);
    cr("m23 status", 10'h126, 16'h0003);
    nz <= 4'h0;
    tick(2);
    nz <= 4'hF;
    tick(3);
    cr("m23 rise", 10'h12A, 16'h0003);
    // Errors stay dropped for two frame starts after OOF ends
    wreg(10'h12A, 16'hFFFF);
    m23 <= 1'b0;
    nz <= 4'h0;
    live[2] <= 1'b0;
    live[1] <= 1'b1;
    tick(2);
    live[1] <= 1'b0;
    pulse(7'h08);
    pulse(7'h40);
    pulse(7'h08);
    cr("holdoff drop", 10'h12A, 16'h0000);
    pulse(7'h40);
    pulse(7'h08);
    cr("holdoff end", 10'h12A, 16'h0200);
    @(posedge sys_clk_i);
    for (int n = 0; n < 400; n++)
    begin
      r = $random(seed);
      {live, ev, nz, m23, ung, glb, sel} <= r[27:0];
      @(posedge sys_clk_i);
      ef = {15'h0000, exp_frm(sel, ev, ung, live[1], live[2])};
      #1 chk("frm evt", ef, {15'h0000, frm_evt});
      @(posedge sys_clk_i);
    end
    final_report();
  end
  initial
  begin
    tick(30000);
    error_cnt++;
    final_report();
  end
endmodule
